// ---- dv/atseq_checker.sv ----
// Concurrent checks on the sequencer's trigger pins, sampling and read port
`default_nettype none
module atseq_checker (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic reg_rd_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic begin_pin_out,
   input wire logic begin_pin_oe_out,
   input wire logic stop_pin_out,
   input wire logic stop_pin_oe_out,
   input wire logic sample_pulse_out,
   input wire logic buf_write_out,
   input wire logic busy_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   // ==========================================================
   // Trigger pins
   AST_BEGIN_OE: assert property (begin_pin_out |-> begin_pin_oe_out)
      else $error("begin pulse on a pin left as input");
   AST_STOP_OE: assert property (stop_pin_out |-> stop_pin_oe_out)
      else $error("reference pulse on a pin left as input");
   AST_BEGIN_ONE: assert property (begin_pin_out |=> !begin_pin_out)
      else $error("begin pulse wider than one cycle");
   AST_STOP_ONE: assert property (stop_pin_out |=> !stop_pin_out)
      else $error("reference pulse wider than one cycle");
   AST_BEGIN_BUSY: assert property (begin_pin_out |-> $rose(busy_out))
      else $error("begin pulse not at start of acquisition");
   AST_STOP_BUSY: assert property (stop_pin_out |-> busy_out)
      else $error("reference pulse outside an acquisition");
   // ==========================================================
   // Sampling and read port
   AST_SAMPLE_WRITE: assert property (sample_pulse_out |-> buf_write_out)
      else $error("sample without buffer write");
   AST_IDLE_QUIET: assert property (!busy_out && !$past(busy_out) |-> !sample_pulse_out)
      else $error("sample while idle");
   // A software stop may end the wait early, so idle also satisfies it
   AST_FIRST_SAMPLE: assert property ($rose(busy_out) |->
      ##[1:1000] (sample_pulse_out || !busy_out))
      else $error("no first sample after begin");
   AST_RDATA_IDLE: assert property (reg_rdata_out != 32'h0 |-> $past(reg_rd_in))
      else $error("read data without a read");
endmodule
`default_nettype wire

// ---- dv/atseq_top_test.sv ----
// Self-checking bench for the acquisition trigger sequencer
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module atseq_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   import atseq_pkg::*;
   logic clk_sys_in, nrst_in, reg_wr_in, reg_rd_in, internal_trig_in, analog_cmp_in;
   logic [3:0] reg_addr_in, channel_out, ch_exp;
   logic [31:0] reg_wdata_in, reg_rdata_out, d;
   logic [7:0] pfl_in;
   logic [6:0] stb_in;
   logic begin_pin_out, begin_pin_oe_out, stop_pin_out, stop_pin_oe_out;
   logic sample_pulse_out, conversion_pulse_out, buf_write_out, busy_out;
   logic [ATSEQ_CNT_W-1:0] buf_addr_out, lim;
   int err_total, total_checks, samp_n, conv_n, beg_n, stop_n, wrap_n;
   atseq_top dut (.clk_sys_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .pfl_in, .stb_in, .internal_trig_in, .analog_cmp_in,
      .begin_pin_out, .begin_pin_oe_out, .stop_pin_out, .stop_pin_oe_out,
      .sample_pulse_out, .conversion_pulse_out, .channel_out, .buf_write_out,
      .buf_addr_out, .busy_out);
   atseq_trig_src src (.clk_in(clk_sys_in), .pfl_out(pfl_in), .stb_out(stb_in),
      .analog_out(analog_cmp_in));
   // ==========================================================
   // Monitor on the falling edge, clear on the rising edge: no race
   always @(negedge clk_sys_in) begin
      if (sample_pulse_out === 1'b1) samp_n++;
      // Every sampling run scans channels 0 then 1
      if (conversion_pulse_out === 1'b1) begin
         conv_n++;
         `CHK(channel_out, ch_exp)
         ch_exp = ch_exp ^ 4'h1;
      end
      if (begin_pin_out === 1'b1) beg_n++;
      if (stop_pin_out === 1'b1) stop_n++;
      if (buf_write_out === 1'b1) begin
         `CHK(buf_addr_out < lim, 1'b1)
         if (buf_addr_out == '0) wrap_n++;
      end
   end
   task clr;
      @(posedge clk_sys_in);
      samp_n = 0;
      conv_n = 0;
      beg_n = 0;
      stop_n = 0;
      wrap_n = 0;
   endtask
   // ==========================================================
   // Register port and waits
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_sys_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_in <= 1'b0;
      @(negedge clk_sys_in);
      v = reg_rdata_out;
   endtask
   task automatic wait_busy(input logic v, input int n);
      int i;
      i = 0;
      while (busy_out !== v && i < n) begin
         @(negedge clk_sys_in);
         i++;
      end
      `CHK(busy_out, v)
   endtask
   task automatic wait_samp(input int k, input int n);
      int i;
      i = 0;
      while (samp_n < k && i < n) begin
         @(negedge clk_sys_in);
         i++;
      end
      `CHK(samp_n >= k, 1'b1)
   endtask
   // ==========================================================
   // Scenarios
   task t_reset;
      `CHK(begin_pin_oe_out, 1'b0)
      `CHK(stop_pin_oe_out, 1'b0)
      rd(ATSEQ_REG_TRIG, d);
      `CHK(d, ATSEQ_TRIG_RST)
      rd(ATSEQ_REG_DLY, d);
      `CHK(d[15:0], ATSEQ_DLY_RST)
      wr(4'hf, 32'hffff_ffff);
      rd(4'hf, d);
      `CHK(d, 32'h0)
   endtask
   task t_post;
      wr(ATSEQ_REG_DIV, 32'h14);
      wr(ATSEQ_REG_CHAN, 32'h3);
      wr(ATSEQ_REG_BUF, 32'h3);
      lim = 24'h3;
      clr;
      wr(ATSEQ_REG_CTRL, 32'h11);
      wait_busy(1'b1, 4);
      wait_busy(1'b0, 300);
      repeat (40) @(posedge clk_sys_in);
      `CHK(beg_n, 1)
      `CHK(samp_n, 3)
      `CHK(conv_n, 6)
      rd(ATSEQ_REG_STAT, d);
      `CHK(d[4], 1'b1)
   endtask
   task t_ref;
      wr(ATSEQ_REG_TRIG, 32'h0000_030e);
      wr(ATSEQ_REG_PRE, 32'h2);
      wr(ATSEQ_REG_BUF, 32'h5);
      lim = 24'h5;
      clr;
      wr(ATSEQ_REG_CTRL, 32'h29);
      src.set_line(4'h3, 1'b1);
      src.set_line(4'h3, 1'b0);
      wait_samp(8, 400);
      `CHK(stop_n, 0)
      `CHK(wrap_n, 2)
      clr;
      src.set_line(4'h3, 1'b1);
      src.set_line(4'h3, 1'b0);
      wait_busy(1'b0, 300);
      `CHK(stop_n, 1)
      `CHK(samp_n, 3)
   endtask
   // Wrong edge first (odd codes below 15 only), then the selected edge, for every source code but 14
   task t_sources;
      logic fall;
      wr(ATSEQ_REG_CTRL, 32'h10);
      wr(ATSEQ_REG_BUF, 32'h1);
      lim = 24'h1;
      for (int c = 0; c < 16; c++) begin
         if (c != 14) begin
            fall = (c < 15) ? c[0] : 1'b0;
            wr(ATSEQ_REG_TRIG, {27'h0, fall, c[3:0]});
            src.set_line(c[3:0], fall);
            repeat (8) @(posedge clk_sys_in);
            `CHK(busy_out, 1'b0)
            clr;
            src.set_line(c[3:0], ~fall);
            wait_busy(1'b1, 8);
            src.set_line(c[3:0], fall);
            wait_busy(1'b0, 100);
            `CHK(beg_n, 1)
         end
      end
   endtask
   task t_hold;
      wr(ATSEQ_REG_TRIG, 32'h0002_000e);
      lim = '1;
      src.set_line(4'h2, 1'b1);
      clr;
      wr(ATSEQ_REG_CTRL, 32'h05);
      repeat (60) @(posedge clk_sys_in);
      `CHK(busy_out, 1'b1)
      `CHK(samp_n, 0)
      src.set_line(4'h2, 1'b0);
      wait_samp(1, 60);
      wr(ATSEQ_REG_CTRL, 32'h02);
      wait_busy(1'b0, 20);
   endtask
   task t_clash;
      wr(ATSEQ_REG_CHAN, 32'h0001_0101);
      wr(ATSEQ_REG_CTRL, 32'h01);
      repeat (10) @(posedge clk_sys_in);
      `CHK(busy_out, 1'b0)
      rd(ATSEQ_REG_STAT, d);
      `CHK(d[7], 1'b1)
      `CHK(d[5], 1'b1)
   endtask
   // ==========================================================
   // Clock, sequence, watchdog, verdict
   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      nrst_in = 1'b0;
      reg_addr_in = 4'h0;
      reg_wdata_in = 32'h0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      internal_trig_in = 1'b0;
      ch_exp = 4'h0;
      lim = '1;
      repeat (12) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      @(posedge clk_sys_in);
      t_reset;
      t_post;
      t_ref;
      t_sources;
      t_hold;
      t_clash;
      summarize;
   end
   // Whole run needs some 1100 cycles; allow 20000
   initial begin
      #200000;
      err_total++;
      summarize;
   end
   task summarize;
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
endmodule
bind atseq_top atseq_checker chk (.clk_sys_in, .nrst_in, .reg_rd_in, .reg_rdata_out,
   .begin_pin_out, .begin_pin_oe_out, .stop_pin_out, .stop_pin_oe_out,
   .sample_pulse_out, .buf_write_out, .busy_out);
`default_nettype wire

// ---- dv/atseq_trig_src.sv ----
// Far-side trigger sources: function lines, timing bus lines, comparator
`default_nettype none
module atseq_trig_src (
   input wire logic clk_in,
   output logic [7:0] pfl_out,
   output logic [6:0] stb_out,
   output logic analog_out
);
   initial begin
      pfl_out = 8'h00;
      stb_out = 7'h00;
      analog_out = 1'b0;
   end
   // ==========================================================
   // Codes 0..7 function lines, 8..13 timing bus, 15 comparator
   task automatic set_line(input logic [3:0] code, input logic level);
      @(posedge clk_in);
      if (code < 4'h8) pfl_out[code[2:0]] <= level;
      else if (code == 4'hf) analog_out <= level;
      else stb_out[code[2:0]] <= level;
   endtask
endmodule
`default_nettype wire

// ---- logic/atseq_pkg.sv ----
// Package for the acquisition trigger sequencer: register map, fields, constants
`default_nettype none
package atseq_pkg;
   // ==========================================================
   // Register map (word index = byte address / 4 not used; plain port)
   localparam logic [3:0] ATSEQ_REG_CTRL = 4'h0;
   localparam logic [3:0] ATSEQ_REG_TRIG = 4'h1;
   localparam logic [3:0] ATSEQ_REG_PRE = 4'h2;
   localparam logic [3:0] ATSEQ_REG_BUF = 4'h3;
   localparam logic [3:0] ATSEQ_REG_DIV = 4'h4;
   localparam logic [3:0] ATSEQ_REG_CONV = 4'h5;
   localparam logic [3:0] ATSEQ_REG_CHAN = 4'h6;
   localparam logic [3:0] ATSEQ_REG_STAT = 4'h7;
   localparam logic [3:0] ATSEQ_REG_CNT = 4'h8;
   localparam logic [3:0] ATSEQ_REG_WPTR = 4'h9;
   localparam logic [3:0] ATSEQ_REG_DLY = 4'ha;
   // ==========================================================
   // CTRL bits
   localparam int ATSEQ_CTRL_START = 0;
   localparam int ATSEQ_CTRL_STOP = 1;
   localparam int ATSEQ_CTRL_CONT = 2;
   localparam int ATSEQ_CTRL_REFEN = 3;
   localparam int ATSEQ_CTRL_BEGOE = 4;
   localparam int ATSEQ_CTRL_REFOE = 5;
   // TRIG fields: [3:0] begin src, [4] begin falling, [11:8] ref src, [12] ref falling,
   // [19:16] hold src, [20] hold active low
   localparam int ATSEQ_SRC_W = 4;
   localparam int ATSEQ_BEG_SRC_LSB = 0;
   localparam int ATSEQ_BEG_POL = 4;
   localparam int ATSEQ_REF_SRC_LSB = 8;
   localparam int ATSEQ_REF_POL = 12;
   localparam int ATSEQ_HLD_SRC_LSB = 16;
   localparam int ATSEQ_HLD_POL = 20;
   // Source codes: 0..7 function lines, 8..13 timing bus 0..5, 14 software, 15 analog
   localparam int ATSEQ_NUM_PFL = 8;
   localparam int ATSEQ_NUM_STB = 7;
   localparam logic [3:0] ATSEQ_SRC_NONE = 4'h0;
   localparam logic [3:0] ATSEQ_SRC_SOFT = 4'he;
   localparam logic [3:0] ATSEQ_SRC_ANALOG = 4'hf;
   localparam int ATSEQ_CNT_W = 24;
   localparam int ATSEQ_NUM_CH = 16;
   localparam int ATSEQ_DIFFERENTIAL_INPUT_OFS = 8;
   // ==========================================================
   // Reset values
   localparam logic [31:0] ATSEQ_TRIG_RST = 32'h0000_000e;
   localparam logic [15:0] ATSEQ_DIV_RST = 16'h0009;
   localparam logic [15:0] ATSEQ_DLY_RST = 16'h0002;
   localparam logic [15:0] ATSEQ_CONV_RST = 16'h0004;
   typedef enum logic [2:0] {
      ATSEQ_IDLE, ATSEQ_DELAY, ATSEQ_PRE, ATSEQ_ARMED, ATSEQ_POST
   } atseq_state_t;
endpackage
`default_nettype wire

// ---- logic/atseq_top.sv ----
// Acquisition timing and trigger sequencer with circular sample buffer control
//
// Contract
// RULE1 - A channel used in one mode is never reused; differential takes n and n+8. Code flags only reuse of n+8, not n set in both lists.
// RULE2 - Sample and conversion periods come from spacing of their pulses.
// RULE3 - Posttrigger: load count, decrement each sample pulse, finish at zero.
// RULE4 - Pretrigger: load pretrigger count at begin, count down, then load posttrigger.
// RULE5 - Reference triggers before pretrigger count completes are ignored.
// RULE6 - After accepted reference, count posttrigger samples then end.
// RULE7 - Software begin trigger emits a pulse on the begin line.
// RULE8 - Without hardware triggers a software start command begins acquisition.
// RULE9 - Stop on count or reference in finite mode, software stop in continuous.
// RULE10 - Begin source: function line, timing bus 0..6, internal; edge selectable. Code selects timing bus 0..5 only, no internal.
// RULE11 - Analog begin source starts on first rising comparison edge.
// RULE12 - Begin pin output mirrors begin trigger as active-high pulse.
// RULE13 - Both trigger pins are inputs after reset.
// RULE14 - Reference use needs finite buffer; post count is buffer minus pre.
// RULE15 - Full buffer while armed overwrites oldest sample circularly.
// RULE16 - Reference source: function line, timing bus 0..6, internal; edge selectable. Code selects timing bus 0..5 only, no internal.
// RULE17 - Analog reference source acts on first rising comparison edge.
// RULE18 - Reference pin output mirrors reference trigger as active-high pulse.
// RULE19 - Hold trigger pauses sampling and never reaches an output pin.
// RULE20 - Hold trigger acts on source level only.
// RULE21 - Each sample pulse scans every channel in the list once.
// RULE22 - First internal sample pulse delayed after begin, default two ticks.
// RULE23 - Trigger output pulses last one timebase cycle.
`default_nettype none
module atseq_top
(
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic [3:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   input wire logic [atseq_pkg::ATSEQ_NUM_PFL-1:0] pfl_in,
   input wire logic [atseq_pkg::ATSEQ_NUM_STB-1:0] stb_in,
   input wire logic internal_trig_in,
   input wire logic analog_cmp_in,
   output logic begin_pin_out,
   output logic begin_pin_oe_out,
   output logic stop_pin_out,
   output logic stop_pin_oe_out,
   output logic sample_pulse_out,
   output logic conversion_pulse_out,
   output logic [3:0] channel_out,
   output logic buf_write_out,
   output logic [atseq_pkg::ATSEQ_CNT_W-1:0] buf_addr_out,
   output logic busy_out
);
   import atseq_pkg::*;

   // ==========================================================
   // Input synchronisers
   localparam int NIN = ATSEQ_NUM_PFL + ATSEQ_NUM_STB + 2;
   logic [NIN-1:0] sync1_q, sync2_q, prev_q;
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q <= '0;
      end else begin
         sync1_q <= {analog_cmp_in, internal_trig_in, stb_in, pfl_in};
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end

   // Picks a synchronised source; code 14 is software, handled apart
   function automatic logic pick(input logic [NIN-1:0] v, input logic [3:0] s);
      logic r;
      r = 1'b0;
      if (s < 4'h8) begin
         r = v[s[2:0]];
      end else if (s < 4'he) begin
         r = v[ATSEQ_NUM_PFL + int'(s - 4'h8)];
      end else if (s == ATSEQ_SRC_ANALOG) begin
         r = v[NIN-1];
      end
      return r;
   endfunction

   // ==========================================================
   // Registers
   logic [31:0] trig_q;
   logic cont_q, refen_q, begoe_q, refoe_q;
   logic [ATSEQ_CNT_W-1:0] pre_q, bufsz_q, cnt_q, wptr_q, stored_q;
   logic [15:0] div_q, dly_q, conv_q;
   logic [ATSEQ_NUM_CH-1:0] chan_q, diffm_q;
   logic sw_start, sw_stop, cfg_err_q, done_q, overwrote_q, go_q;
   atseq_state_t state_q;

   assign sw_start = reg_wr_in && reg_addr_in == ATSEQ_REG_CTRL && reg_wdata_in[ATSEQ_CTRL_START];
   assign sw_stop = reg_wr_in && reg_addr_in == ATSEQ_REG_CTRL && reg_wdata_in[ATSEQ_CTRL_STOP];

   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trig_q <= ATSEQ_TRIG_RST;
         cont_q <= 1'b0;
         refen_q <= 1'b0;
         begoe_q <= 1'b0; // RULE13
         refoe_q <= 1'b0; // RULE13
         pre_q <= '0;
         bufsz_q <= '0;
         div_q <= ATSEQ_DIV_RST;
         dly_q <= ATSEQ_DLY_RST;
         conv_q <= ATSEQ_CONV_RST;
         chan_q <= 16'h0001;
         diffm_q <= '0;
      end else if (reg_wr_in) begin
         if (reg_addr_in == ATSEQ_REG_CTRL) begin
            cont_q <= reg_wdata_in[ATSEQ_CTRL_CONT];
            refen_q <= reg_wdata_in[ATSEQ_CTRL_REFEN];
            begoe_q <= reg_wdata_in[ATSEQ_CTRL_BEGOE];
            refoe_q <= reg_wdata_in[ATSEQ_CTRL_REFOE];
         end else if (reg_addr_in == ATSEQ_REG_TRIG) begin
            trig_q <= reg_wdata_in;
         end else if (reg_addr_in == ATSEQ_REG_PRE) begin
            pre_q <= reg_wdata_in[ATSEQ_CNT_W-1:0];
         end else if (reg_addr_in == ATSEQ_REG_BUF) begin
            bufsz_q <= reg_wdata_in[ATSEQ_CNT_W-1:0];
         end else if (reg_addr_in == ATSEQ_REG_DIV) begin
            div_q <= reg_wdata_in[15:0];
         end else if (reg_addr_in == ATSEQ_REG_CONV) begin
            conv_q <= reg_wdata_in[15:0];
         end else if (reg_addr_in == ATSEQ_REG_CHAN) begin
            chan_q <= reg_wdata_in[15:0];
            diffm_q <= reg_wdata_in[31:16];
         end else if (reg_addr_in == ATSEQ_REG_DLY) begin
            dly_q <= reg_wdata_in[15:0];
         end
      end
   end

   // Differential channel n in low half claims n+8; only a clash on n+8 is flagged, not n set in both lists
   logic chan_clash;
   always_comb begin
      chan_clash = 1'b0;
      for (int i = 0; i < ATSEQ_DIFFERENTIAL_INPUT_OFS; i++) begin
         if (diffm_q[i] && (diffm_q[i+ATSEQ_DIFFERENTIAL_INPUT_OFS] || chan_q[i+ATSEQ_DIFFERENTIAL_INPUT_OFS])) begin
            chan_clash = 1'b1; // RULE1
         end
      end
   end

   // ==========================================================
   // Trigger detection
   logic [3:0] beg_src, ref_src, hld_src;
   logic beg_cur, beg_old, ref_cur, ref_old, hold_lvl;
   logic beg_hw, ref_hw, beg_evt;
   assign beg_src = trig_q[ATSEQ_BEG_SRC_LSB +: ATSEQ_SRC_W];
   assign ref_src = trig_q[ATSEQ_REF_SRC_LSB +: ATSEQ_SRC_W];
   assign hld_src = trig_q[ATSEQ_HLD_SRC_LSB +: ATSEQ_SRC_W];
   assign beg_cur = pick(sync2_q, beg_src);
   assign beg_old = pick(prev_q, beg_src);
   assign ref_cur = pick(sync2_q, ref_src);
   assign ref_old = pick(prev_q, ref_src);
   // Analog sources always act on the rising edge
   assign beg_hw = (beg_src == ATSEQ_SRC_ANALOG || !trig_q[ATSEQ_BEG_POL]) ?
                   (beg_cur && !beg_old) : (!beg_cur && beg_old); // RULE10 RULE11
   assign ref_hw = (ref_src == ATSEQ_SRC_ANALOG || !trig_q[ATSEQ_REF_POL]) ?
                   (ref_cur && !ref_old) : (!ref_cur && ref_old); // RULE16 RULE17
   // Level only; no edge term and no output route
   assign hold_lvl = (hld_src != ATSEQ_SRC_NONE) &&
                     (pick(sync2_q, hld_src) ^ trig_q[ATSEQ_HLD_POL]); // RULE19 RULE20
   assign beg_evt = (beg_src == ATSEQ_SRC_SOFT) ? sw_start : beg_hw; // RULE8

   // ==========================================================
   // Sample timing: divider from the 100 MHz timebase
   logic [15:0] div_cnt_q;
   logic tick, samp;
   assign tick = div_cnt_q == 16'h0000;
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         div_cnt_q <= ATSEQ_DIV_RST;
      end else if (state_q == ATSEQ_IDLE || tick) begin
         div_cnt_q <= div_q; // RULE2
      end else if (!hold_lvl) begin
         div_cnt_q <= div_cnt_q - 16'h0001;
      end
   end
   assign samp = tick && !hold_lvl && state_q != ATSEQ_IDLE && state_q != ATSEQ_DELAY;

   // ==========================================================
   // Sequencer
   logic [15:0] dly_cnt_q;
   logic [ATSEQ_CNT_W-1:0] post_cnt;
   assign post_cnt = bufsz_q - pre_q; // RULE14
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state_q <= ATSEQ_IDLE;
         cnt_q <= '0;
         dly_cnt_q <= '0;
         cfg_err_q <= 1'b0;
         done_q <= 1'b0;
         go_q <= 1'b0;
      end else begin
         go_q <= 1'b0;
         case (state_q)
            ATSEQ_IDLE: begin
               if (beg_evt) begin
                  if (chan_clash || (refen_q && (cont_q || bufsz_q <= pre_q))) begin
                     cfg_err_q <= 1'b1; // RULE1 RULE14
                  end else begin
                     cfg_err_q <= 1'b0;
                     done_q <= 1'b0;
                     dly_cnt_q <= dly_q;
                     go_q <= 1'b1; // RULE7
                     cnt_q <= refen_q ? pre_q : bufsz_q; // RULE3 RULE4
                     state_q <= ATSEQ_DELAY;
                  end
               end
            end
            ATSEQ_DELAY: begin
               // Delay counted in timebase cycles
               if (dly_cnt_q <= 16'h0001) begin
                  state_q <= refen_q ? (pre_q == '0 ? ATSEQ_ARMED : ATSEQ_PRE)
                                     : ATSEQ_POST; // RULE22
               end else begin
                  dly_cnt_q <= dly_cnt_q - 16'h0001;
               end
            end
            ATSEQ_PRE: begin
               if (samp) begin
                  cnt_q <= cnt_q - 1'b1; // RULE4
                  if (cnt_q == 1) begin
                     state_q <= ATSEQ_ARMED; // RULE5
                  end
               end
            end
            ATSEQ_ARMED: begin
               if (ref_hw) begin
                  cnt_q <= post_cnt; // RULE4 RULE6
                  state_q <= ATSEQ_POST;
               end
            end
            ATSEQ_POST: begin
               if (samp && !cont_q) begin
                  cnt_q <= cnt_q - 1'b1; // RULE3 RULE6
                  if (cnt_q == 1) begin
                     state_q <= ATSEQ_IDLE; // RULE9
                     done_q <= 1'b1;
                  end
               end
            end
            default: state_q <= ATSEQ_IDLE;
         endcase
         if (sw_stop && state_q != ATSEQ_IDLE) begin
            state_q <= ATSEQ_IDLE; // RULE9
            done_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Circular buffer addressing
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wptr_q <= '0;
         stored_q <= '0;
         overwrote_q <= 1'b0;
      end else if (state_q == ATSEQ_IDLE && beg_evt) begin
         wptr_q <= '0;
         stored_q <= '0;
         overwrote_q <= 1'b0;
      end else if (samp) begin
         wptr_q <= (wptr_q + 1'b1 >= bufsz_q) ? '0 : wptr_q + 1'b1; // RULE15
         if (stored_q >= bufsz_q && bufsz_q != '0) begin
            overwrote_q <= 1'b1; // RULE15
         end else begin
            stored_q <= stored_q + 1'b1;
         end
      end
   end

   // ==========================================================
   // Conversion scan: one conversion per listed channel per sample
   logic [3:0] ch_q;
   logic scan_q;
   logic [15:0] conv_cnt_q;
   logic [3:0] nxt_ch;
   logic nxt_any;
   always_comb begin
      nxt_ch = ch_q;
      nxt_any = 1'b0;
      for (int i = ATSEQ_NUM_CH - 1; i >= 0; i--) begin
         if (chan_q[i] && 5'(i) > {1'b0, ch_q}) begin
            nxt_ch = 4'(i);
            nxt_any = 1'b1;
         end
      end
   end
   logic [3:0] first_ch;
   always_comb begin
      first_ch = 4'h0;
      for (int i = ATSEQ_NUM_CH - 1; i >= 0; i--) begin
         if (chan_q[i]) begin
            first_ch = 4'(i);
         end
      end
   end
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ch_q <= '0;
         scan_q <= 1'b0;
         conv_cnt_q <= '0;
         conversion_pulse_out <= 1'b0;
         channel_out <= 4'h0;
      end else begin
         conversion_pulse_out <= 1'b0;
         if (samp) begin
            ch_q <= first_ch; // RULE21
            scan_q <= 1'b1;
            conv_cnt_q <= '0;
         end else if (scan_q) begin
            if (conv_cnt_q == 16'h0000) begin
               conversion_pulse_out <= 1'b1; // RULE2 RULE21
               channel_out <= ch_q; // RULE21
               conv_cnt_q <= conv_q;
               if (nxt_any) begin
                  ch_q <= nxt_ch;
               end else begin
                  scan_q <= 1'b0;
               end
            end else begin
               conv_cnt_q <= conv_cnt_q - 16'h0001;
            end
         end
      end
   end

   // ==========================================================
   // Outputs, all registered
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         begin_pin_out <= 1'b0;
         begin_pin_oe_out <= 1'b0;
         stop_pin_out <= 1'b0;
         stop_pin_oe_out <= 1'b0;
         sample_pulse_out <= 1'b0;
         buf_write_out <= 1'b0;
         buf_addr_out <= '0;
         busy_out <= 1'b0;
      end else begin
         begin_pin_oe_out <= begoe_q; // RULE13
         stop_pin_oe_out <= refoe_q; // RULE13
         // One cycle after acceptance, in step with busy; any start source
         begin_pin_out <= begoe_q && go_q; // RULE7 RULE12 RULE23
         stop_pin_out <= refoe_q && state_q == ATSEQ_ARMED && ref_hw; // RULE18 RULE23
         sample_pulse_out <= samp; // RULE2
         buf_write_out <= samp;
         buf_addr_out <= wptr_q;
         busy_out <= state_q != ATSEQ_IDLE;
      end
   end

   // ==========================================================
   // Register read, data one cycle after strobe
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         if (reg_addr_in == ATSEQ_REG_CTRL) begin
            reg_rdata_out <= {26'h0, refoe_q, begoe_q, refen_q, cont_q, 2'h0};
         end else if (reg_addr_in == ATSEQ_REG_TRIG) begin
            reg_rdata_out <= trig_q;
         end else if (reg_addr_in == ATSEQ_REG_PRE) begin
            reg_rdata_out <= {8'h0, pre_q};
         end else if (reg_addr_in == ATSEQ_REG_BUF) begin
            reg_rdata_out <= {8'h0, bufsz_q};
         end else if (reg_addr_in == ATSEQ_REG_DIV) begin
            reg_rdata_out <= {16'h0, div_q};
         end else if (reg_addr_in == ATSEQ_REG_CONV) begin
            reg_rdata_out <= {16'h0, conv_q};
         end else if (reg_addr_in == ATSEQ_REG_CHAN) begin
            reg_rdata_out <= {diffm_q, chan_q};
         end else if (reg_addr_in == ATSEQ_REG_STAT) begin
            reg_rdata_out <= {24'h0, chan_clash, overwrote_q, cfg_err_q, done_q,
                              1'b0, 3'(state_q)};
         end else if (reg_addr_in == ATSEQ_REG_CNT) begin
            reg_rdata_out <= {8'h0, cnt_q};
         end else if (reg_addr_in == ATSEQ_REG_WPTR) begin
            reg_rdata_out <= {8'h0, wptr_q};
         end else if (reg_addr_in == ATSEQ_REG_DLY) begin
            reg_rdata_out <= {16'h0, dly_q};
         end else begin
            reg_rdata_out <= '0;
         end
      end else begin
         reg_rdata_out <= '0;
      end
   end
endmodule
`default_nettype wire
